// ===== rtcwk_top.sv
`timescale 1ns/1ps
module rtcwk_top import rtcwk_pkg::*; (
	input wire logic hclk, // Bus clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic hready, // Bus ready
	input wire logic [31:0] hwdata, // Write data
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic rtc_osc, // 32.768 kHz oscillator pin
	input wire logic hour_tick, // Hour advance pin, rising edge
	input wire logic alarm_match, // Alarm compare pin, rising edge
	input wire logic vcc_below_vbat, // Supply comparator pin
	input wire logic port1_normal, // Normal port 1 bit 7 value
	output logic port1_bit7, // Port 1 bit 7 output value
	output logic port1_bit7_oe, // Port 1 bit 7 output enable
	output logic [5:0] cap_adjust_bits, // Oscillator capacitance adjust
	output logic crystal_load_select, // Crystal load choice
	output logic alarm_pending, // Alarm flag level
	output logic retention_active // Retention mode level
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] meta_ff;
	logic [4:0] sync_ff;
	logic [2:0] prev_ff;

	// Two flops per pin, then one more stage for edge detection on the three edge pins only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_ff <= 5'h00;
			sync_ff <= 5'h00;
			prev_ff <= 3'h0;
		end else begin
			meta_ff <= {port1_normal, vcc_below_vbat, alarm_match, hour_tick, rtc_osc};
			sync_ff <= meta_ff;
			prev_ff <= sync_ff[2:0];
		end
	end

	// Rising edges of the synced pins and the retention level
	logic osc_rise;
	logic hour_rise;
	logic alarm_rise;
	logic in_retention;
	assign osc_rise = sync_ff[0] & ~prev_ff[0];
	assign hour_rise = sync_ff[1] & ~prev_ff[1];
	assign alarm_rise = sync_ff[2] & ~prev_ff[2];
	assign in_retention = sync_ff[3];

	// ----------------------------------------------------------------
	// AHB-Lite address phase and decode
	// ----------------------------------------------------------------
	// Word index and select for a transfer taken this cycle
	logic [7:0] a_idx;
	logic a_valid;
	logic a_in_range;
	logic a_mapped;
	logic [PLAIN_N-1:0] a_plain_hit;
	assign a_idx = haddr[9:2];
	assign a_valid = hsel & htrans[1] & hready;
	assign a_in_range = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
	assign a_mapped = a_in_range & ((a_idx == IDX_OSC_TUNING) | (a_idx == IDX_CLOCK_CONTROL)
		| (a_idx == IDX_TIME_HOUR_WEEKDAY) | (|a_plain_hit));

	// Write held over into its data phase
	logic wr_pend_ff;
	logic [7:0] wr_idx_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= 8'h00;
		end else begin
			wr_pend_ff <= a_valid & hwrite & a_mapped;
			wr_idx_ff <= a_idx;
		end
	end

	// Data phase write, dropped in retention
	logic wr_ok;
	logic [7:0] wd;
	assign wr_ok = wr_pend_ff & ~in_retention;
	assign wd = hwdata[7:0];

	// ----------------------------------------------------------------
	// Plain storage registers
	// ----------------------------------------------------------------
	// Storage-only registers, one per plain index
	logic [7:0] plain_ff [PLAIN_N];
	logic [7:0] plain_rd [PLAIN_N];
	genvar gi;
	generate
		for (gi = 0; gi < PLAIN_N; gi++) begin : g_plain
			assign a_plain_hit[gi] = a_in_range & (a_idx == PLAIN_IDX[gi]);
			assign plain_rd[gi] = a_plain_hit[gi] ? plain_ff[gi] : 8'h00;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					plain_ff[gi] <= PLAIN_RESET;
				end else if (wr_ok && wr_idx_ff == PLAIN_IDX[gi]) begin
					plain_ff[gi] <= wd;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Oscillator tuning register
	// ----------------------------------------------------------------
	// Trim write decode; legal only with a complemented half
	logic tick_en_ff;
	logic xload_ff;
	logic [5:0] cap_ff;
	logic trim_wr;
	logic trim_legal;
	assign trim_wr = wr_ok & (wr_idx_ff == IDX_OSC_TUNING);
	assign trim_legal = (wd[5:3] == ~wd[2:0]);

	// Legal writes store all bits; illegal ones recover and keep load select
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_en_ff <= 1'b0;
			xload_ff <= XLOAD_12P5PF;
			cap_ff <= CAP_ADJUST_RESET;
		end else if (trim_wr && trim_legal) begin
			tick_en_ff <= wd[TRIM_TICK_EN_BIT];
			xload_ff <= wd[TRIM_XLOAD_BIT];
			cap_ff <= wd[5:0];
		end else if (trim_wr) begin
			tick_en_ff <= 1'b0;
			cap_ff <= CAP_ADJUST_RECOVER;
		end
	end

	// ----------------------------------------------------------------
	// Clock control and alarm flag
	// ----------------------------------------------------------------
	// Clock control write and alarm flag set
	logic [7:0] cc_ff;
	logic cc_wr;
	logic [7:0] nxt_cc;
	logic flag_set;
	logic cmp_any;
	assign cc_wr = wr_ok & (wr_idx_ff == IDX_CLOCK_CONTROL);
	assign nxt_cc = cc_wr ? wd : cc_ff;
	assign cmp_any = |nxt_cc[7:4];
	assign flag_set = alarm_rise & cmp_any;

	// Set wins over a software clear; no compare enable clears the flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cc_ff <= CC_RESET;
		end else begin
			cc_ff <= {nxt_cc[7:2], (nxt_cc[CC_FLAG_BIT] & cmp_any) | flag_set, nxt_cc[0]};
		end
	end

	// ----------------------------------------------------------------
	// Hour and weekday
	// ----------------------------------------------------------------
	// Hour step and day rollover decode
	logic [4:0] hour_ff;
	logic [2:0] weekday_ff;
	logic hr_wr;
	logic day_roll;
	logic [4:0] nxt_hour;
	logic [2:0] nxt_weekday;
	assign hr_wr = wr_ok & (wr_idx_ff == IDX_TIME_HOUR_WEEKDAY) & cc_ff[CC_WRITE_EN_BIT];
	assign day_roll = hour_rise & cc_ff[CC_RUN_BIT] & (hour_ff == HOUR_LAST);
	assign nxt_hour = day_roll ? HOUR_FIRST : 5'(hour_ff + 5'h01);
	assign nxt_weekday = (weekday_ff == WEEKDAY_OFF) ? WEEKDAY_OFF :
		(weekday_ff == WEEKDAY_LAST) ? WEEKDAY_FIRST :
		3'(weekday_ff + 3'h1);

	// Weekday steps on the same tick as the hour rollover; software write takes priority
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hour_ff <= HOUR_FIRST;
			weekday_ff <= WEEKDAY_RESET;
		end else if (hr_wr) begin
			hour_ff <= wd[4:0];
			weekday_ff <= wd[7:5];
		end else if (hour_rise && cc_ff[CC_RUN_BIT]) begin
			hour_ff <= nxt_hour;
			if (day_roll) begin
				weekday_ff <= nxt_weekday;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path with forwarding of a plain register write in its data phase
	// ----------------------------------------------------------------
	// Merge of the plain register read values
	logic [7:0] plain_or;
	always_comb begin
		plain_or = 8'h00;
		for (int i = 0; i < PLAIN_N; i++) begin
			plain_or = plain_or | plain_rd[i];
		end
	end

	// Register select and plain write forwarding
	logic [7:0] rd_val;
	logic fwd;
	assign rd_val = (a_idx == IDX_OSC_TUNING) ? {tick_en_ff, xload_ff, cap_ff} :
		(a_idx == IDX_CLOCK_CONTROL) ? cc_ff :
		(a_idx == IDX_TIME_HOUR_WEEKDAY) ? {weekday_ff, hour_ff} : plain_or;
	assign fwd = wr_pend_ff & (wr_idx_ff == a_idx) & (a_idx != IDX_OSC_TUNING)
		& (a_idx != IDX_CLOCK_CONTROL) & (a_idx != IDX_TIME_HOUR_WEEKDAY);

	// Read data captured at the address phase; zero if unmapped or retained
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (a_valid && !hwrite) begin
				hrdata <= (!a_mapped || in_retention) ? 32'h00000000 :
					{24'h000000, (fwd && !in_retention) ? wd : rd_val};
			end
		end
	end

	// ----------------------------------------------------------------
	// Test tick divider and port 1 bit 7
	// ----------------------------------------------------------------
	// Divide synced oscillator edges by eight
	logic [1:0] div_ff;
	logic tick_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_ff <= 2'h0;
			tick_ff <= 1'b0;
		end else if (!tick_en_ff) begin
			div_ff <= 2'h0;
			tick_ff <= 1'b0;
		end else if (osc_rise) begin
			div_ff <= (div_ff == TICK_HALF_LAST) ? 2'h0 : 2'(div_ff + 2'h1);
			if (div_ff == TICK_HALF_LAST) begin
				tick_ff <= ~tick_ff;
			end
		end
	end

	// Pin value and drive come from flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port1_bit7 <= 1'b0;
			port1_bit7_oe <= 1'b0;
			cap_adjust_bits <= CAP_ADJUST_RESET;
			crystal_load_select <= XLOAD_12P5PF;
			alarm_pending <= 1'b0;
			retention_active <= 1'b0;
		end else begin
			port1_bit7 <= tick_en_ff ? tick_ff : sync_ff[4];
			port1_bit7_oe <= tick_en_ff;
			cap_adjust_bits <= cap_ff;
			crystal_load_select <= xload_ff;
			alarm_pending <= cc_ff[CC_FLAG_BIT];
			retention_active <= in_retention;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Named steps used by the properties below
	sequence s_roll_at_last;
		day_roll && !hr_wr && weekday_ff == WEEKDAY_LAST;
	endsequence
	sequence s_illegal_trim;
		trim_wr && !trim_legal;
	endsequence
	sequence s_legal_trim;
		trim_wr && trim_legal;
	endsequence
	sequence s_plain_hour_step;
		hour_rise && cc_ff[CC_RUN_BIT] && !hr_wr && !day_roll;
	endsequence

	// Weekday counting and software writes
	a_weekday_wrap: assert property (s_roll_at_last |=> weekday_ff == WEEKDAY_FIRST)
		else $error("weekday did not wrap to one");
	a_weekday_hold: assert property (weekday_ff == WEEKDAY_OFF && !hr_wr
		|=> weekday_ff == WEEKDAY_OFF)
		else $error("disabled weekday moved");
	a_weekday_step: assert property (day_roll && !hr_wr && weekday_ff != WEEKDAY_OFF
		&& weekday_ff != WEEKDAY_LAST |=> weekday_ff == 3'($past(weekday_ff) + 3'h1))
		else $error("weekday did not advance");
	a_day_same_tick: assert property (!$past(hr_wr) && $changed(weekday_ff)
		|-> hour_ff == HOUR_FIRST && $past(hour_ff) == HOUR_LAST)
		else $error("weekday changed apart from hour rollover");
	a_hour_only: assert property (s_plain_hour_step |=> $stable(weekday_ff))
		else $error("weekday moved without a day rollover");
	a_hour_zero: assert property (day_roll && !hr_wr |=> hour_ff == HOUR_FIRST)
		else $error("hour did not roll to zero");
	a_weekday_write: assert property (hr_wr |=> weekday_ff == $past(wd[7:5])
		&& hour_ff == $past(wd[4:0]))
		else $error("hour register write not taken");

	// Oscillator tuning
	a_trim_recover: assert property (s_illegal_trim |=> cap_ff == CAP_ADJUST_RECOVER
		&& !tick_en_ff && xload_ff == $past(xload_ff))
		else $error("illegal trim not recovered");
	a_trim_store: assert property (trim_wr && trim_legal |=> cap_ff == $past(wd[5:0]))
		else $error("legal trim not stored");
	a_trim_fields: assert property (s_legal_trim |=>
		tick_en_ff == $past(wd[TRIM_TICK_EN_BIT]) && xload_ff == $past(wd[TRIM_XLOAD_BIT]))
		else $error("legal trim fields not stored");
	a_cap_output: assert property (1'b1 |=> cap_adjust_bits == $past(cap_ff)
		&& crystal_load_select == $past(xload_ff))
		else $error("trim outputs differ from register");

	// Retention, alarm flag and bus answer
	a_retain_nowrite: assert property (wr_pend_ff && in_retention && !hour_rise |=>
		$stable(cap_ff) && $stable(hour_ff) && $stable(cc_ff[7:2]))
		else $error("write taken in retention");
	a_plain_retain: assert property (wr_pend_ff && in_retention |=>
		$stable(plain_ff[0]) && $stable(plain_ff[PLAIN_N-1]))
		else $error("plain register written in retention");
	a_retain_read: assert property (a_valid && !hwrite && in_retention
		|=> hrdata == 32'h00000000)
		else $error("read in retention returned data");
	a_retain_level: assert property (1'b1 |=> retention_active == $past(in_retention))
		else $error("retention level not shown");
	a_flag_pending: assert property (flag_set |=> cc_ff[CC_FLAG_BIT] ##1 alarm_pending)
		else $error("alarm flag not set");
	a_flag_hold: assert property (cc_ff[CC_FLAG_BIT] && !cc_wr |=> cc_ff[CC_FLAG_BIT])
		else $error("pending alarm flag lost");
	a_flag_clear: assert property (cc_wr && wd[7:4] == 4'h0
		|=> !cc_ff[CC_FLAG_BIT])
		else $error("alarm flag kept with compares off");
	a_bus_okay: assert property (a_valid |=> hreadyout && !hresp)
		else $error("bus answer not ready or not okay");

	// Port 1 bit 7
	a_port_release: assert property (!tick_en_ff |=> !port1_bit7_oe
		&& port1_bit7 == $past(sync_ff[4]))
		else $error("port still driven with tick off");
	a_tick_quarter: assert property (tick_en_ff && $changed(tick_ff)
		|-> $past(osc_rise) && $past(div_ff) == TICK_HALF_LAST)
		else $error("tick toggled off its divide point");
	a_tick_drive: assert property (tick_en_ff |=> port1_bit7_oe
		&& port1_bit7 == $past(tick_ff))
		else $error("test tick not driven on port");
endmodule // rtcwk_top

// ===== rtcwk_pkg.sv
package rtcwk_pkg;
	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_OSC_TUNING = 8'h96;
	localparam logic [7:0] IDX_ALARM_SUBSECOND = 8'hF2;
	localparam logic [7:0] IDX_ALARM_SECOND = 8'hF3;
	localparam logic [7:0] IDX_ALARM_MINUTE = 8'hF4;
	localparam logic [7:0] IDX_ALARM_HOUR = 8'hF5;
	localparam logic [7:0] IDX_CLOCK_CONTROL = 8'hF9;
	localparam logic [7:0] IDX_TIME_SUBSECOND = 8'hFA;
	localparam logic [7:0] IDX_TIME_SECOND = 8'hFB;
	localparam logic [7:0] IDX_TIME_MINUTE = 8'hFC;
	localparam logic [7:0] IDX_TIME_HOUR_WEEKDAY = 8'hFD;
	localparam logic [7:0] IDX_DAY_COUNT_LOW = 8'hFE;
	localparam logic [7:0] IDX_DAY_COUNT_HIGH = 8'hFF;
	localparam int PLAIN_N = 9;
	localparam logic [7:0] PLAIN_IDX [PLAIN_N] = '{8'hF2, 8'hF3, 8'hF4, 8'hF5,
		8'hFA, 8'hFB, 8'hFC, 8'hFE, 8'hFF};

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TRIM_TICK_EN_BIT = 7;
	localparam int TRIM_XLOAD_BIT = 6;
	localparam int CC_FLAG_BIT = 1;
	localparam int CC_WRITE_EN_BIT = 2;
	localparam int CC_RUN_BIT = 0;

	// ----------------------------------------------------------------
	// Values after reset and fixed patterns
	// ----------------------------------------------------------------
	localparam logic XLOAD_12P5PF = 1'b1;
	localparam logic [5:0] CAP_ADJUST_RECOVER = 6'h25;
	localparam logic [5:0] CAP_ADJUST_RESET = 6'h25;
	localparam logic [7:0] CC_RESET = 8'h00;
	localparam logic [7:0] PLAIN_RESET = 8'h00;
	localparam logic [4:0] HOUR_LAST = 5'h17;
	localparam logic [4:0] HOUR_FIRST = 5'h00;
	localparam logic [2:0] WEEKDAY_OFF = 3'h0;
	localparam logic [2:0] WEEKDAY_FIRST = 3'h1;
	localparam logic [2:0] WEEKDAY_LAST = 3'h7;
	localparam logic [2:0] WEEKDAY_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Timing: 32.768 kHz divided by eight gives 4096 Hz
	// ----------------------------------------------------------------
	localparam int OSC_DIVIDE = 8;
	localparam logic [1:0] TICK_HALF_LAST = 2'(OSC_DIVIDE / 2 - 1);
endpackage

// ===== rtcwk_cpu.sv
`timescale 1ns/1ps
module rtcwk_cpu (
	input wire logic hclk, // Bus clock
	input wire logic hready, // Bus ready
	input wire logic [31:0] hrdata, // Read data
	output logic hsel, // Slave select
	output logic [31:0] haddr, // Byte address
	output logic [1:0] htrans, // Transfer type
	output logic hwrite, // Write when high
	output logic [2:0] hsize, // Transfer size
	output logic [31:0] hwdata, // Write data
	output logic hung // Bus wait ran out
);
	// ----------------------------------------------------------------
	// Core side of the register bus
	// ----------------------------------------------------------------
	// Idle bus from time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hung = 1'b0;
	end

	// Wait for hready at a rising edge, never longer than the bound
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1) begin
			hung = 1'b1;
		end
	endtask

	// One single word transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
			output logic [7:0] q);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_ready();
		q = hrdata[7:0];
	endtask
endmodule // rtcwk_cpu

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top import rtcwk_pkg::*;;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, hung;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic rtc_osc = 1'b0;
	logic hour_tick = 1'b0;
	logic alarm_match = 1'b0;
	logic vcc_below_vbat = 1'b0;
	logic port1_normal = 1'b0;
	logic port1_bit7, port1_bit7_oe, crystal_load_select, alarm_pending, retention_active;
	logic [5:0] cap_adjust_bits;
	int bad_count = 0;
	int checked = 0;
	int osc_n = 0;

	// ----------------------------------------------------------------
	// Clocks and instances
	// ----------------------------------------------------------------
	// Crystal stand-in, much faster than the real one to keep the run short
	always #2.5 hclk = ~hclk;
	always #100 rtc_osc = ~rtc_osc;
	always @(posedge rtc_osc) osc_n++;

	rtcwk_top i_rtcwk_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rtc_osc(rtc_osc),
		.hour_tick(hour_tick), .alarm_match(alarm_match), .vcc_below_vbat(vcc_below_vbat),
		.port1_normal(port1_normal), .port1_bit7(port1_bit7), .port1_bit7_oe(port1_bit7_oe),
		.cap_adjust_bits(cap_adjust_bits), .crystal_load_select(crystal_load_select),
		.alarm_pending(alarm_pending), .retention_active(retention_active));
	rtcwk_cpu i_rtcwk_cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hung(hung));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Counts, verdict and end of run
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Bus access; a hung bus ends the run
	task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
			output logic [7:0] q);
		i_rtcwk_cpu.xfer(w, idx, d, q);
		if (hung === 1'b1) begin
			bad_count++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, idx, d, q);
	endtask
	// Read after one idle cycle and compare
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		hold(1);
		acc(1'b0, idx, 8'h00, q);
		chk({24'h0, q}, {24'h0, exp});
	endtask
	// Wait for the pin to change, bounded
	task automatic wait_toggle();
		logic v;
		int n;
		v = port1_bit7;
		n = 0;
		while (port1_bit7 === v && n < 1000) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 1000) begin
			bad_count++;
			stop_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rdc(IDX_OSC_TUNING, 8'h65);
		chk(32'(cap_adjust_bits), 32'h25);
		chk(32'(crystal_load_select), 32'h1);
		foreach (PLAIN_IDX[i]) rdc(PLAIN_IDX[i], PLAIN_RESET);
		$display("Test reset done");
	endtask
	task automatic t_plain();
		foreach (PLAIN_IDX[i]) wr(PLAIN_IDX[i], 8'(8'hA0 + i));
		foreach (PLAIN_IDX[i]) rdc(PLAIN_IDX[i], 8'(8'hA0 + i));
		wr(8'h10, 8'h3C);
		rdc(8'h10, 8'h00);
		$display("Test plain done");
	endtask
	task automatic t_trim();
		int n0;
		wr(IDX_OSC_TUNING, 8'h95);
		rdc(IDX_OSC_TUNING, 8'h95);
		chk(32'(cap_adjust_bits), 32'h15);
		chk(32'(crystal_load_select), 32'h0);
		hold(4);
		chk(32'(port1_bit7_oe), 32'h1);
		wait_toggle();
		n0 = osc_n;
		wait_toggle();
		chk(32'(osc_n - n0), 32'h4);
		wr(IDX_OSC_TUNING, 8'hFF);
		rdc(IDX_OSC_TUNING, 8'h25);
		chk(32'(crystal_load_select), 32'h0);
		chk(32'(cap_adjust_bits), 32'h25);
		port1_normal <= 1'b1;
		hold(6);
		chk(32'(port1_bit7_oe), 32'h0);
		chk(32'(port1_bit7), 32'h1);
		$display("Test trim done");
	endtask
	task automatic t_weekday();
		logic [7:0] tw [5] = '{8'hF7, 8'h57, 8'h17, 8'h00, 8'h25};
		logic [7:0] te [5] = '{8'h20, 8'h60, 8'h00, 8'h01, 8'h26};
		wr(IDX_CLOCK_CONTROL, 8'h05);
		for (int i = 0; i < 5; i++) begin
			wr(IDX_TIME_HOUR_WEEKDAY, tw[i]);
			hour_tick <= 1'b1;
			hold(8);
			hour_tick <= 1'b0;
			hold(8);
			rdc(IDX_TIME_HOUR_WEEKDAY, te[i]);
		end
		wr(IDX_CLOCK_CONTROL, 8'h01);
		wr(IDX_TIME_HOUR_WEEKDAY, 8'h00);
		rdc(IDX_TIME_HOUR_WEEKDAY, te[4]);
		$display("Test weekday done");
	endtask
	task automatic t_retention();
		wr(IDX_CLOCK_CONTROL, 8'h15);
		wr(IDX_ALARM_SECOND, 8'h33);
		vcc_below_vbat <= 1'b1;
		hold(6);
		chk(32'(retention_active), 32'h1);
		wr(IDX_ALARM_SECOND, 8'h5A);
		rdc(IDX_ALARM_SECOND, 8'h00);
		alarm_match <= 1'b1;
		hold(6);
		alarm_match <= 1'b0;
		hold(6);
		chk(32'(alarm_pending), 32'h1);
		vcc_below_vbat <= 1'b0;
		hold(6);
		chk(32'(retention_active), 32'h0);
		rdc(IDX_ALARM_SECOND, 8'h33);
		rdc(IDX_CLOCK_CONTROL, 8'h17);
		wr(IDX_CLOCK_CONTROL, 8'h05);
		hold(3);
		chk(32'(alarm_pending), 32'h0);
		$display("Test retention done");
	endtask

	// Main sequence
	initial begin
		hold(16);
		hresetn <= 1'b1;
		hold(1);
		t_reset();
		t_plain();
		t_trim();
		t_weekday();
		t_retention();
		stop_test();
	end
endmodule // tb_top
